// [rtl/dcs_pkg.sv]
package dcs_pkg;
  // Parallel port geometry
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int SYNC_STAGES = 3;
  // Device control page: address bits 6:3 all ones
  localparam int PAGE_LSB = 3;
  localparam logic [3:0] DEV_PAGE = 4'h000f;
  localparam logic [6:0] ADDR_DEV_CTRL = 7'h0078;
  localparam logic [6:0] ADDR_ROUTE = 7'h0079;
  localparam logic [6:0] ADDR_SELFTEST = 7'h007d;
  localparam logic [6:0] ADDR_STATUS = 7'h007e;
  localparam logic [6:0] ADDR_IMM = 7'h007f;
  // Reset values
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_ROUTE = 16'h0000;
  localparam logic [15:0] RD_ZERO = 16'h0000;
  // Device control fields
  localparam int TESTMODE_BIT = 14;
  // Self-test register fields
  localparam int VALID_BIT = 15;
  localparam int SIG_MSB = 14;
  localparam int SIG_LSB = 3;
  localparam int SIG_W = 12;
  localparam int REV_MSB = 2;
  localparam int REV_W = 3;
  // Status register fields
  localparam int N_CHAN = 4;
  localparam int CH_STAT_W = 16;
  localparam int CHAN_FAULT_LSB = 12;
  localparam int OUT_FAULT_BIT = 11;
  localparam int N_SAT = 10;
  localparam logic [15:0] CH_FAULT_MASK = 16'h0788;
  // Immediate action fields
  localparam int IMM_RST_BIT = 1;
  localparam int IMM_SYNC_BIT = 0;
  // Summer data widths
  localparam int SUM_IN_W = 21;
  localparam int SUM_OUT_W = 20;
  // Self-test compactor
  localparam int BIST_LEN = 256;
  localparam logic [11:0] BIST_TAPS = 12'h0829;
  localparam logic [11:0] BIST_SEED = 12'h0001;

  typedef enum logic [2:0] {
    DCS_BIST_IDLE = 3'b001,
    DCS_BIST_RUN = 3'b010,
    DCS_BIST_DONE = 3'b100
  } dcs_bist_state_t;
endpackage

// [rtl/dcs_bist.sv]
`timescale 1ns/1ps
module dcs_bist #(
  parameter int LEN = dcs_pkg::BIST_LEN
) (
  input wire logic clk_sys,
  input wire logic clr,
  input wire logic run_en,
  input wire logic start,
  input wire logic [dcs_pkg::SIG_W-1:0] stim,
  output logic [dcs_pkg::SIG_W-1:0] sig_q,
  output logic done_q
);
  localparam int CW = $clog2(LEN) + 1;
  localparam logic [CW-1:0] LAST = CW'(LEN - 1);
  localparam logic [CW-1:0] CNT_ZERO = '0;

  dcs_pkg::dcs_bist_state_t state_q;
  logic [CW-1:0] cnt_q;
  logic fb;

  assign fb = ^(sig_q & dcs_pkg::BIST_TAPS);

  // Sequencer; a drop of run_en aborts so a stale signature never completes
  always_ff @(posedge clk_sys) begin
    if (clr || !run_en) begin
      state_q <= dcs_pkg::DCS_BIST_IDLE;
      cnt_q <= CNT_ZERO;
    end else begin
      case (state_q)
        dcs_pkg::DCS_BIST_IDLE: begin
          if (start) begin
            state_q <= dcs_pkg::DCS_BIST_RUN;
            cnt_q <= CNT_ZERO;
          end
        end
        dcs_pkg::DCS_BIST_RUN: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == LAST) begin
            state_q <= dcs_pkg::DCS_BIST_DONE;
          end
        end
        dcs_pkg::DCS_BIST_DONE: begin
          state_q <= dcs_pkg::DCS_BIST_IDLE;
        end
        default: begin
          state_q <= dcs_pkg::DCS_BIST_IDLE;
        end
      endcase
    end
  end

  // Signature compactor, seeded at start
  always_ff @(posedge clk_sys) begin
    if (clr) begin
      sig_q <= dcs_pkg::BIST_SEED;
    end else if (state_q == dcs_pkg::DCS_BIST_IDLE && start && run_en) begin
      sig_q <= dcs_pkg::BIST_SEED;
    end else if (state_q == dcs_pkg::DCS_BIST_RUN && run_en) begin
      sig_q <= {sig_q[dcs_pkg::SIG_W-2:0], fb} ^ stim;
    end
  end

  // Completion pulse
  always_ff @(posedge clk_sys) begin
    if (clr) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == dcs_pkg::DCS_BIST_RUN) && run_en && (cnt_q == LAST);
    end
  end
endmodule

// [rtl/dcs_sat_clamp.sv]
`timescale 1ns/1ps
module dcs_sat_clamp #(
  parameter int IN_W = dcs_pkg::SUM_IN_W,
  parameter int OUT_W = dcs_pkg::SUM_OUT_W
) (
  input wire logic clk_sys,
  input wire logic clr,
  input wire logic signed [IN_W-1:0] sum_in,
  output logic signed [OUT_W-1:0] out_q,
  output logic sat_q
);
  // Symmetric range: negative limit is most negative plus one
  localparam logic signed [OUT_W-1:0] MAX_POS = {1'b0, {(OUT_W-1){1'b1}}};
  localparam logic signed [OUT_W-1:0] MAX_NEG = -MAX_POS;
  localparam logic signed [IN_W-1:0] WIDE_POS = IN_W'(MAX_POS);
  localparam logic signed [IN_W-1:0] WIDE_NEG = -WIDE_POS;

  // Registered clamp with one-cycle saturation event
  always_ff @(posedge clk_sys) begin
    if (clr) begin
      out_q <= '0;
      sat_q <= 1'b0;
    end else if (sum_in > WIDE_POS) begin
      out_q <= MAX_POS;
      sat_q <= 1'b1;
    end else if (sum_in < WIDE_NEG) begin
      out_q <= MAX_NEG;
      sat_q <= 1'b1;
    end else begin
      out_q <= sum_in[OUT_W-1:0];
      sat_q <= 1'b0;
    end
  end

  a_clamp_range: assert property (@(posedge clk_sys) disable iff (clr)
    sat_q |-> (out_q == MAX_POS || out_q == MAX_NEG))
    else $error("clamp output outside symmetric limit");
endmodule

// [rtl/dcs_regs.sv]
`timescale 1ns/1ps
// Operation
// - Routing register applies on update strobe only
// - Immediate action is write-only, reads zero
// - Self-test register is read-only
// - Valid flag clears on test-mode change, sets
// - Twelve-bit signature field in self-test register
// - Fixed revision code in low three bits
// - Per-channel fault flags in status bits 15:12
// - Channel fault is OR of status 10:7,3
// - Cascade and summer saturation flags in 9:0
// - Saturation clamps to symmetric limits
// - Writing one clears summary fault bits
// - Channel clear also clears channel status word
// - Output fault clear clears all saturation flags
// - Immediate bit one gives hard reset pulse
// - Device idles after hard reset
// - Immediate bit zero gives sync-out pulse
// - Master cleared by hard, slave by both
module dcs_regs #(
  parameter logic [dcs_pkg::REV_W-1:0] REVISION = 3'h5, // Arbitrary value
  parameter int BIST_LEN = dcs_pkg::BIST_LEN
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [dcs_pkg::ADDR_W-1:0] addr,
  input wire logic [dcs_pkg::DATA_W-1:0] data_in,
  output logic [dcs_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic update_strobe_n,
  input wire logic soft_rst,
  input wire logic [dcs_pkg::N_CHAN*dcs_pkg::CH_STAT_W-1:0] chan_status,
  input wire logic [dcs_pkg::N_SAT*dcs_pkg::SUM_IN_W-1:0] sum_in,
  output logic [dcs_pkg::N_SAT*dcs_pkg::SUM_OUT_W-1:0] sum_out,
  output logic [dcs_pkg::N_CHAN-1:0] chan_status_clr,
  output logic [dcs_pkg::DATA_W-1:0] device_control,
  output logic [dcs_pkg::DATA_W-1:0] output_routing,
  output logic hard_reset_pulse,
  output logic sync_out_pulse
);
  localparam int NS = dcs_pkg::SYNC_STAGES;
  localparam int BW = dcs_pkg::ADDR_W + dcs_pkg::DATA_W + 4;

  // Pin synchronisers: stage 0 is read only by stage 1
  logic [BW-1:0] pin_s [NS];
  logic cs_n_s, wr_n_s, wr_n_prev, rd_n_s, upd_n_s, upd_n_prev;
  logic [dcs_pkg::ADDR_W-1:0] addr_s;
  logic [dcs_pkg::DATA_W-1:0] wdata_s;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int k = 0; k < NS; k++) begin
        pin_s[k] <= {{(BW-4){1'b0}}, 4'hf};
      end
    end else begin
      pin_s[0] <= {addr, data_in, cs_n, wr_n, rd_n, update_strobe_n};
      for (int k = 1; k < NS; k++) begin
        pin_s[k] <= pin_s[k-1];
      end
    end
  end

  // Last stage carries the bus; wr and update edges use stages 1 and 2
  assign {addr_s, wdata_s, cs_n_s, wr_n_prev, rd_n_s, upd_n_prev} = pin_s[NS-1];
  assign wr_n_s = pin_s[NS-2][2];
  assign upd_n_s = pin_s[NS-2][0];

  // Decode: write taken on the rising edge of the write strobe
  logic in_page, wr_evt, rd_act, upd_evt;
  assign in_page = (addr_s[dcs_pkg::ADDR_W-1:dcs_pkg::PAGE_LSB] == dcs_pkg::DEV_PAGE);
  assign wr_evt = !cs_n_s && !wr_n_prev && wr_n_s && in_page;
  assign rd_act = !cs_n_s && !rd_n_s && in_page;
  assign upd_evt = !upd_n_prev && upd_n_s;

  logic wr_ctrl, wr_route, wr_status, wr_imm;
  assign wr_ctrl = wr_evt && (addr_s == dcs_pkg::ADDR_DEV_CTRL);
  assign wr_route = wr_evt && (addr_s == dcs_pkg::ADDR_ROUTE);
  assign wr_status = wr_evt && (addr_s == dcs_pkg::ADDR_STATUS);
  assign wr_imm = wr_evt && (addr_s == dcs_pkg::ADDR_IMM);

  // Immediate actions: self-clearing one-cycle pulses
  logic hard_rst_q, sync_out_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hard_rst_q <= 1'b0;
      sync_out_q <= 1'b0;
    end else begin
      hard_rst_q <= wr_imm && wdata_s[dcs_pkg::IMM_RST_BIT];
      sync_out_q <= wr_imm && wdata_s[dcs_pkg::IMM_SYNC_BIT];
    end
  end

  // Hard reset covers the pin reset and the immediate-action pulse
  logic clr_all, clr_slv;
  assign clr_all = !rst_n || hard_rst_q;
  assign clr_slv = clr_all || soft_rst;

  // Master stage, written from the strobe, cleared only by hard reset
  logic [dcs_pkg::DATA_W-1:0] ctrl_m_q, route_m_q;
  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      ctrl_m_q <= dcs_pkg::RST_CTRL;
      route_m_q <= dcs_pkg::RST_ROUTE;
    end else begin
      if (wr_ctrl) begin
        ctrl_m_q <= wdata_s;
      end
      if (wr_route) begin
        route_m_q <= wdata_s;
      end
    end
  end

  // Slave stage; control follows the master every cycle, routing only on the update strobe, so a second routing write before it replaces the first
  logic [dcs_pkg::DATA_W-1:0] ctrl_s_q, route_s_q;
  always_ff @(posedge clk_sys) begin
    if (clr_slv) begin
      ctrl_s_q <= dcs_pkg::RST_CTRL;
      route_s_q <= dcs_pkg::RST_ROUTE;
    end else begin
      ctrl_s_q <= ctrl_m_q;
      if (upd_evt) begin
        route_s_q <= route_m_q;
      end
    end
  end

  // Test mode edge tracking for the self-test valid flag
  logic tm_q, tm_prev_q, tm_rise, tm_chg;
  assign tm_q = ctrl_s_q[dcs_pkg::TESTMODE_BIT];
  assign tm_rise = tm_q && !tm_prev_q;
  assign tm_chg = tm_q != tm_prev_q;
  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      tm_prev_q <= 1'b0;
    end else begin
      tm_prev_q <= tm_q;
    end
  end

  logic [dcs_pkg::SIG_W-1:0] bist_sig;
  logic bist_done;
  dcs_bist #(
    .LEN(BIST_LEN)
  ) u_bist (
    .clk_sys(clk_sys),
    .clr(clr_all),
    .run_en(tm_q),
    .start(tm_rise),
    .stim(ctrl_s_q[dcs_pkg::SIG_W-1:0] ^ route_s_q[dcs_pkg::SIG_W-1:0]),
    .sig_q(bist_sig),
    .done_q(bist_done)
  );

  // Valid flag: any test-mode change wins over a completion
  logic valid_q;
  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      valid_q <= 1'b0;
    end else if (tm_chg) begin
      valid_q <= 1'b0;
    end else if (bist_done) begin
      valid_q <= 1'b1;
    end
  end

  // Saturating summers, one per cascade or output path
  logic [dcs_pkg::N_SAT-1:0] sat_pulse;
  genvar g;
  generate
    for (g = 0; g < dcs_pkg::N_SAT; g++) begin : g_sat
      dcs_sat_clamp #(
        .IN_W(dcs_pkg::SUM_IN_W),
        .OUT_W(dcs_pkg::SUM_OUT_W)
      ) u_clamp (
        .clk_sys(clk_sys),
        .clr(clr_all),
        .sum_in(sum_in[g*dcs_pkg::SUM_IN_W +: dcs_pkg::SUM_IN_W]),
        .out_q(sum_out[g*dcs_pkg::SUM_OUT_W +: dcs_pkg::SUM_OUT_W]),
        .sat_q(sat_pulse[g])
      );
    end
  endgenerate

  // Saturation flags and output fault: set wins over a same-cycle clear
  logic [dcs_pkg::N_SAT-1:0] sat_q;
  logic out_fault_q, out_clr;
  assign out_clr = wr_status && wdata_s[dcs_pkg::OUT_FAULT_BIT];
  always_ff @(posedge clk_sys) begin
    if (clr_slv) begin
      sat_q <= '0;
      out_fault_q <= 1'b0;
    end else begin
      sat_q <= (sat_q & ~{dcs_pkg::N_SAT{out_clr}}) | sat_pulse;
      out_fault_q <= (out_fault_q && !out_clr) || (|sat_pulse);
    end
  end

  // Channel summary faults, one per channel
  logic [dcs_pkg::N_CHAN-1:0] ch_fault_q, ch_set, ch_clr;
  generate
    for (g = 0; g < dcs_pkg::N_CHAN; g++) begin : g_chan
      assign ch_set[g] = |(chan_status[g*dcs_pkg::CH_STAT_W +: dcs_pkg::CH_STAT_W]
                           & dcs_pkg::CH_FAULT_MASK);
      assign ch_clr[g] = wr_status && wdata_s[dcs_pkg::CHAN_FAULT_LSB + g];
      always_ff @(posedge clk_sys) begin
        if (clr_slv) begin
          ch_fault_q[g] <= 1'b0;
          chan_status_clr[g] <= 1'b0;
        end else begin
          ch_fault_q[g] <= (ch_fault_q[g] && !ch_clr[g]) || ch_set[g];
          chan_status_clr[g] <= ch_clr[g];
        end
      end
    end
  endgenerate

  // Read mux; reserved and unused locations return zero
  logic [dcs_pkg::DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = dcs_pkg::RD_ZERO;
    case (addr_s)
      dcs_pkg::ADDR_DEV_CTRL: rd_mux = ctrl_s_q;
      dcs_pkg::ADDR_ROUTE: rd_mux = route_s_q;
      dcs_pkg::ADDR_SELFTEST: begin
        rd_mux[dcs_pkg::VALID_BIT] = valid_q;
        rd_mux[dcs_pkg::SIG_MSB:dcs_pkg::SIG_LSB] = bist_sig;
        rd_mux[dcs_pkg::REV_MSB:0] = REVISION;
      end
      dcs_pkg::ADDR_STATUS: begin
        rd_mux[dcs_pkg::CHAN_FAULT_LSB +: dcs_pkg::N_CHAN] = ch_fault_q;
        rd_mux[dcs_pkg::OUT_FAULT_BIT] = out_fault_q;
        rd_mux[dcs_pkg::N_SAT-1:0] = sat_q;
      end
      dcs_pkg::ADDR_IMM: rd_mux = dcs_pkg::RD_ZERO;
      default: rd_mux = dcs_pkg::RD_ZERO;
    endcase
  end

  // Registered read port; drive only while the host reads this page
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      data_out <= dcs_pkg::RD_ZERO;
      data_oe <= 1'b0;
    end else begin
      data_oe <= rd_act;
      data_out <= rd_act ? rd_mux : dcs_pkg::RD_ZERO;
    end
  end

  // Output registers toward the datapath
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      device_control <= dcs_pkg::RST_CTRL;
      output_routing <= dcs_pkg::RST_ROUTE;
      hard_reset_pulse <= 1'b0;
      sync_out_pulse <= 1'b0;
    end else begin
      device_control <= ctrl_s_q;
      output_routing <= route_s_q;
      hard_reset_pulse <= hard_rst_q;
      sync_out_pulse <= sync_out_q;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_hard_rst_pulse: assert property (
    wr_imm && wdata_s[dcs_pkg::IMM_RST_BIT] |=> hard_rst_q
      ##1 (!hard_rst_q && hard_reset_pulse) ##1 !hard_reset_pulse)
    else $error("hard reset pulse missing or not self clearing");
  a_sync_pulse: assert property (
    wr_imm && wdata_s[dcs_pkg::IMM_SYNC_BIT] |=> ##1 sync_out_pulse)
    else $error("sync out pulse missing");
  a_route_hold: assert property (
    !upd_evt && !clr_slv |=> $stable(route_s_q))
    else $error("routing changed without update strobe");
  a_valid_clear: assert property (
    tm_chg && !clr_all |=> !valid_q)
    else $error("valid flag kept over test mode change");
  a_valid_set: assert property (
    bist_done && !tm_chg && !clr_all |=> valid_q)
    else $error("valid flag not set at completion");
  a_chan_fault_set: assert property (
    ch_set[0] && !clr_slv |=> ch_fault_q[0])
    else $error("channel fault not set");
  a_sat_sticky: assert property (
    sat_q[0] && !out_clr && !clr_slv |=> sat_q[0])
    else $error("saturation flag lost");
  a_out_fault_set: assert property (
    (|sat_pulse) && !clr_slv |=> out_fault_q)
    else $error("output fault not set on saturation");
  a_out_clear_all: assert property (
    out_clr && sat_pulse == '0 && !clr_slv |=> sat_q == '0)
    else $error("saturation flags survive output fault clear");
  a_chan_word_clr: assert property (
    ch_clr[0] && !clr_slv |=> chan_status_clr[0])
    else $error("channel status clear not issued");
  a_master_reset: assert property (
    hard_rst_q |=> ctrl_m_q == dcs_pkg::RST_CTRL && route_m_q == dcs_pkg::RST_ROUTE)
    else $error("master registers not cleared by hard reset");
  a_imm_reads_zero: assert property (
    rd_act && addr_s == dcs_pkg::ADDR_IMM |=> data_oe && data_out == dcs_pkg::RD_ZERO)
    else $error("immediate action read not zero");

  c_hard_reset: cover property (hard_rst_q);
  c_sync_out: cover property (sync_out_pulse);
  c_bist_valid: cover property (!valid_q ##1 valid_q);
  c_chan_fault: cover property (ch_fault_q[0] && ch_clr[0]);
endmodule

// [verif/dcs_host_model.sv]
`timescale 1ns/1ps
// Host side of the parallel port; one access at a time, strobes idle high
module dcs_host_model (
  input wire logic clk_sys,
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic [dcs_pkg::ADDR_W-1:0] addr,
  output logic [dcs_pkg::DATA_W-1:0] data_in,
  input wire logic [dcs_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe
);
  // Idle bus at time zero
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    addr = 7'h00;
    data_in = 16'h0000;
  end

  // Write cycle; released lines show the inverse so stale data never passes as fresh
  task automatic write_reg(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #2;
    cs_n = 1'b0;
    addr = a;
    data_in = d; // Callers keep reserved bits at zero
    wr_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #2 wr_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    #2 cs_n = 1'b1;
    data_in = ~d;
    addr = ~a;
    // Let the synchronised update finish before the address is reused
    repeat (5) @(posedge clk_sys);
  endtask

  // Read cycle; strobes held until the block is seen driving, bounded wait
  task automatic read_reg(input logic [6:0] a, output logic [15:0] d, output logic oe);
    int n;
    n = 0;
    @(posedge clk_sys);
    #2;
    cs_n = 1'b0;
    addr = a;
    rd_n = 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (data_oe !== 1'b1 && n < 10);
    oe = data_oe;
    d = data_out;
    #2 cs_n = 1'b1;
    rd_n = 1'b1;
    addr = ~a;
    repeat (6) @(posedge clk_sys); // Spacing also covers same-address reuse
  endtask
endmodule

// [verif/tb_device_control_status_regs.sv]
`timescale 1ns/1ps
module tb_device_control_status_regs;
  localparam logic [2:0] REV = 3'h2; // Arbitrary value
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n, wr_n, rd_n, data_oe, oe;
  logic [6:0] addr;
  logic [15:0] data_in, data_out, d, sig;
  logic update_strobe_n = 1'b1;
  logic soft_rst = 1'b0;
  logic [63:0] chan_status = '0;
  logic [209:0] sum_in = '0;
  logic [199:0] sum_out;
  logic [3:0] chan_status_clr;
  logic [15:0] device_control, output_routing;
  logic hard_reset_pulse, sync_out_pulse;
  int miscompares = 0;
  int n_checks = 0;
  int n_hrst = 0;
  int n_sync = 0;
  int n_clr[4] = '{default: 0};
  int cb[5] = '{3, 7, 8, 9, 10};

  always #12.5 clk_sys = ~clk_sys;

  dcs_regs #(.REVISION(REV), .BIST_LEN(8)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .update_strobe_n(update_strobe_n), .soft_rst(soft_rst), .chan_status(chan_status),
    .sum_in(sum_in), .sum_out(sum_out), .chan_status_clr(chan_status_clr),
    .device_control(device_control), .output_routing(output_routing),
    .hard_reset_pulse(hard_reset_pulse), .sync_out_pulse(sync_out_pulse));

  dcs_host_model u_host (
    .clk_sys(clk_sys), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

  // Pulse counters; a pulse that stands two cycles counts twice and shows up
  always @(posedge clk_sys) begin
    if (hard_reset_pulse === 1'b1) n_hrst++;
    if (sync_out_pulse === 1'b1) n_sync++;
    for (int g = 0; g < 4; g++) if (chan_status_clr[g] === 1'b1) n_clr[g]++;
  end

  task automatic check_reg(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask

  task automatic check_sum(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] v);
    u_host.write_reg(a, v);
  endtask

  // Read that must be driven and return the expected word
  task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
    u_host.read_reg(a, d, oe);
    check_reg({15'h0000, oe}, 16'h0001);
    check_reg(d, exp);
  endtask

  // One-cycle sum on path j, clamped output checked the cycle after
  task automatic sat_chk(input int j, input logic [20:0] v, input logic [19:0] exp);
    tick(1);
    sum_in[21*j +: 21] = v;
    tick(1);
    check_sum(sum_out[20*j +: 20], exp);
    sum_in[21*j +: 21] = 21'h00_0000;
  endtask

  task automatic test_done();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Whole run needs under a thousand cycles; give ample margin
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    $display("ERROR at %0t: timeout got 0x0 expected 0x1", $time);
    test_done();
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    #2 rst_n = 1'b1;
    rd_chk(dcs_pkg::ADDR_DEV_CTRL, dcs_pkg::RST_CTRL);
    rd_chk(dcs_pkg::ADDR_ROUTE, dcs_pkg::RST_ROUTE);
    rd_chk(dcs_pkg::ADDR_STATUS, 16'h0000);
    rd_chk(dcs_pkg::ADDR_IMM, 16'h0000);
    $display("test reset_values done");

    wr(dcs_pkg::ADDR_DEV_CTRL, 16'h0003);
    rd_chk(dcs_pkg::ADDR_DEV_CTRL, 16'h0003);
    check_reg(device_control, 16'h0003);
    wr(dcs_pkg::ADDR_ROUTE, 16'h1234);
    check_reg(output_routing, 16'h0000);
    rd_chk(dcs_pkg::ADDR_ROUTE, 16'h0000);
    tick(0);
    update_strobe_n = 1'b0;
    tick(2);
    update_strobe_n = 1'b1;
    tick(6);
    check_reg(output_routing, 16'h1234);
    rd_chk(dcs_pkg::ADDR_ROUTE, 16'h1234);
    tick(0);
    soft_rst = 1'b1;
    tick(1);
    soft_rst = 1'b0;
    rd_chk(dcs_pkg::ADDR_ROUTE, 16'h0000);
    rd_chk(dcs_pkg::ADDR_DEV_CTRL, 16'h0003);
    $display("test control_routing done");

    wr(dcs_pkg::ADDR_SELFTEST, 16'hffff);
    wr(dcs_pkg::ADDR_DEV_CTRL, 16'h4000);
    tick(20);
    u_host.read_reg(dcs_pkg::ADDR_SELFTEST, d, oe);
    check_reg({15'h0000, d[15]}, 16'h0001);
    check_reg({13'h0000, d[2:0]}, {13'h0000, REV});
    // Eight compactor steps from the seed with a zero stimulus word
    sig = {1'b1, 12'h1ee, REV};
    rd_chk(dcs_pkg::ADDR_SELFTEST, sig);
    wr(dcs_pkg::ADDR_DEV_CTRL, 16'h0000);
    u_host.read_reg(dcs_pkg::ADDR_SELFTEST, d, oe);
    check_reg({d[15], 12'h000, d[2:0]}, {13'h0000, REV});
    $display("test selftest done");

    for (int k = 0; k < 5; k++) begin
      tick(1);
      chan_status[16*(k%4)+cb[k]] = 1'b1;
      tick(1);
      chan_status = '0;
      rd_chk(dcs_pkg::ADDR_STATUS, 16'h1000 << (k%4));
      wr(dcs_pkg::ADDR_STATUS, 16'h1000 << (k%4));
      rd_chk(dcs_pkg::ADDR_STATUS, 16'h0000);
      check_reg(16'(n_clr[k%4]), 16'(k/4 + 1));
    end
    tick(1);
    chan_status[0] = 1'b1;
    tick(1);
    chan_status = '0;
    rd_chk(dcs_pkg::ADDR_STATUS, 16'h0000);
    $display("test channel_faults done");

    sat_chk(0, 21'h07_ffff, 20'h7_ffff);
    rd_chk(dcs_pkg::ADDR_STATUS, 16'h0000);
    for (int j = 0; j < 10; j++) begin
      if (j % 2) sat_chk(j, 21'h18_0000, 20'h8_0001);
      else sat_chk(j, 21'h08_0000, 20'h7_ffff);
    end
    rd_chk(dcs_pkg::ADDR_STATUS, 16'h0bff);
    wr(dcs_pkg::ADDR_STATUS, 16'h0800);
    rd_chk(dcs_pkg::ADDR_STATUS, 16'h0000);
    $display("test saturation done");

    wr(dcs_pkg::ADDR_IMM, 16'h0001);
    check_reg(16'(n_sync), 16'h0001);
    check_reg(16'(n_hrst), 16'h0000);
    wr(dcs_pkg::ADDR_DEV_CTRL, 16'h4003);
    tick(1);
    chan_status[19] = 1'b1;
    tick(1);
    chan_status = '0;
    wr(dcs_pkg::ADDR_IMM, 16'h0002);
    check_reg(16'(n_hrst), 16'h0001);
    check_reg(16'(n_sync), 16'h0001);
    check_reg(device_control, 16'h0000);
    rd_chk(dcs_pkg::ADDR_DEV_CTRL, 16'h0000);
    rd_chk(dcs_pkg::ADDR_STATUS, 16'h0000);
    u_host.read_reg(dcs_pkg::ADDR_SELFTEST, d, oe);
    check_reg({d[15], 12'h000, d[2:0]}, {13'h0000, REV});
    $display("test immediate_action done");
    test_done();
  end
endmodule
